// >>> sct_core.sv
`timescale 1ns/1ps
// What this block does
// - Gravity compensation enable bit, default off, takes effect only at restart.
// - Signed gravity torque offset, 0.1 percent steps, -1000 to 1000, immediate.
// - Current control mode 1 or low-noise 2 from select digit, at restart.
// - Current gain level 100 to 2000 percent, immediate; 2000 means no reduction.
// - Speed detection method from select digit, 0 method 1, 1 method 2, at restart.
// - First-order lag on speed feedback, time constant 0.01 ms units, immediate.
// - Motor reference equals position reference plus backlash pulses.
// - Backlash compensation only with a rotary motor connected.
// - Backlash direction 0 forward, 1 reverse, effective at restart.
// - Signed backlash amount, 0.1 unit steps, -500000 to 500000, immediate.
// - Converted pulse count is rounded to a whole number.
// - Skip compensation when amount magnitude exceeds the programmed limit register.
// - Add only with servo on and the last reference step in the configured direction; held while the reference stands still.
// - No compensation with servo off or overtravel; motor reference equals position reference.
// - Reported feedback has the backlash amount removed.
module sct_core #(
   parameter int POS_W = 32,
   parameter int TRQ_W = 16,
   parameter int SPD_W = 24
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic rotary_motor_i,
   input wire logic servo_on_i,
   input wire logic overtravel_i,
   input wire logic signed [POS_W-1:0] pos_ref_i,
   input wire logic signed [POS_W-1:0] feedback_pos_i,
   input wire logic signed [TRQ_W-1:0] torque_ref_i,
   input wire logic signed [SPD_W-1:0] speed_fb_i,
   output logic signed [POS_W-1:0] motor_pos_ref_o,
   output logic signed [POS_W-1:0] host_feedback_pos_o,
   output logic signed [TRQ_W-1:0] torque_cmd_o,
   output logic signed [SPD_W-1:0] speed_fb_filt_o,
   output logic [1:0] current_mode_o,
   output logic speed_detect_method_o,
   output logic [15:0] current_gain_level_o,
   output logic bl_active_o
);

   localparam int FILT_W = sct_pkg::FILT_SHIFT;

   ////////////////////////////////////////////////////////////////////////////
   // Complete block state
   typedef struct packed {
      logic [15:0] cfg_pend;
      logic grav_en;
      logic [1:0] cur_mode;
      logic spd_det;
      logic bl_dir;
      logic signed [15:0] grav_off;
      logic [15:0] cur_gain;
      logic [15:0] filt_tc;
      logic signed [31:0] bl_amt;
      logic [31:0] gear_num;
      logic [31:0] gear_den;
      logic [31:0] bl_limit;
      logic [31:0] rdata;
      logic [2:0] pin_a;
      logic [2:0] pin_b;
      logic signed [POS_W-1:0] prev_ref;
      logic bl_applied;
      logic signed [POS_W-1:0] bl_pulses;
      logic [15:0] tick_cnt;
      logic signed [SPD_W+FILT_W-1:0] filt_acc;
      logic signed [POS_W-1:0] motor_ref;
      logic signed [POS_W-1:0] host_fb;
      logic signed [TRQ_W-1:0] trq;
   } sct_state_s;

   sct_state_s q, d;

   ////////////////////////////////////////////////////////////////////////////

   // Pulse conversion with round to nearest
   function automatic logic signed [POS_W-1:0] to_pulses(input logic signed [31:0] amt,
         input logic [31:0] num, input logic [31:0] den);
      logic signed [95:0] prod;
      logic signed [95:0] dv;
      logic signed [95:0] half;
      prod = 96'(amt) * $signed({64'h0, num});
      dv = $signed({64'h0, den}) * 96'sd10;
      half = dv >>> 1;
      if (prod < 0) begin
         prod = prod - half;
      end else begin
         prod = prod + half;
      end
      to_pulses = POS_W'(prod / dv);
   endfunction

   // Symmetric clamp of a signed setting
   function automatic logic signed [31:0] clamp_sym(input logic signed [31:0] v,
         input logic signed [31:0] lim);
      logic signed [31:0] res;
      res = v;
      if (v > lim) begin
         res = lim;
      end else if (v < -lim) begin
         res = -lim;
      end
      clamp_sym = res;
   endfunction

   // Clamp of an unsigned setting into a window
   function automatic logic [15:0] clamp_win(input logic [31:0] v, input logic [15:0] lo,
         input logic [15:0] hi);
      logic [15:0] res;
      res = v[15:0];
      if (v > 32'(hi)) begin
         res = hi;
      end else if (v < 32'(lo)) begin
         res = lo;
      end
      clamp_win = res;
   endfunction

   // Zero gear term falls back to one
   function automatic logic [31:0] non_zero(input logic [31:0] v);
      logic [31:0] res;
      res = v;
      if (v == 32'h0) begin
         res = sct_pkg::GEAR_DEF;
      end
      non_zero = res;
   endfunction

   // Reference moving in the compensated direction
   function automatic logic step_matches(input logic signed [POS_W-1:0] step, input logic rev);
      logic hit;
      if (rev) begin
         hit = (step < 0);
      end else begin
         hit = (step > 0);
      end
      step_matches = hit;
   endfunction

   // Status word
   function automatic logic [31:0] status_word(input sct_state_s s);
      logic [31:0] res;
      res = {26'h0, s.bl_applied, s.bl_dir, s.spd_det, s.cur_mode, s.grav_en};
      status_word = res;
   endfunction

   // Register read multiplexer
   function automatic logic [31:0] reg_read(input sct_state_s s, input logic [7:0] a);
      logic [31:0] res;
      unique case (a)
         sct_pkg::ADDR_RESTART_CFG: res = {16'h0, s.cfg_pend};
         sct_pkg::ADDR_GRAV_OFFSET: res = 32'(s.grav_off);
         sct_pkg::ADDR_CUR_GAIN: res = {16'h0, s.cur_gain};
         sct_pkg::ADDR_SPD_FILT: res = {16'h0, s.filt_tc};
         sct_pkg::ADDR_BL_AMOUNT: res = s.bl_amt;
         sct_pkg::ADDR_GEAR_NUM: res = s.gear_num;
         sct_pkg::ADDR_GEAR_DEN: res = s.gear_den;
         sct_pkg::ADDR_BL_LIMIT: res = s.bl_limit;
         sct_pkg::ADDR_STATUS: res = status_word(s);
         default: res = 32'h0;
      endcase
      reg_read = res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   logic signed [31:0] bl_abs;
   logic signed [POS_W-1:0] ref_step;
   logic dir_match;
   logic bl_allowed;
   logic signed [SPD_W+FILT_W-1:0] filt_err;
   logic [15:0] tc_div;

   always_comb begin
      d = q;
      // Divisor never zero, filter bypassed then anyway
      tc_div = (q.filt_tc == 16'h0) ? 16'h1 : q.filt_tc;
      // Bus writes
      if (wr_i) begin
         unique case (addr_i)
            sct_pkg::ADDR_RESTART_CFG: d.cfg_pend = wdata_i[15:0];
            sct_pkg::ADDR_GRAV_OFFSET: begin
               d.grav_off = 16'(clamp_sym($signed(wdata_i), 32'(sct_pkg::GRAV_MAX)));
            end
            sct_pkg::ADDR_CUR_GAIN: begin
               d.cur_gain = clamp_win(wdata_i, sct_pkg::CUR_GAIN_MIN, sct_pkg::CUR_GAIN_DEF);
            end
            sct_pkg::ADDR_SPD_FILT: d.filt_tc = wdata_i[15:0];
            sct_pkg::ADDR_BL_AMOUNT: begin
               d.bl_amt = clamp_sym($signed(wdata_i), 32'(sct_pkg::BL_MAX));
            end
            sct_pkg::ADDR_GEAR_NUM: d.gear_num = non_zero(wdata_i);
            sct_pkg::ADDR_GEAR_DEN: d.gear_den = non_zero(wdata_i);
            sct_pkg::ADDR_BL_LIMIT: d.bl_limit = wdata_i;
            sct_pkg::ADDR_RESTART: begin
               // Restart-effective settings latch here
               d.grav_en = q.cfg_pend[sct_pkg::GRAV_EN_BIT];
               d.cur_mode = q.cfg_pend[sct_pkg::CUR_MODE_LSB +: 2];
               d.spd_det = q.cfg_pend[sct_pkg::SPD_DET_LSB];
               d.bl_dir = q.cfg_pend[sct_pkg::BL_DIR_BIT];
            end
            default: ;
         endcase
      end
      // Bus reads, data in the following cycle
      d.rdata = 32'h0;
      if (rd_i) begin
         d.rdata = reg_read(q, addr_i);
      end

      // Pin synchronisers: rotary, servo on, overtravel
      d.pin_a = {rotary_motor_i, servo_on_i, overtravel_i};
      d.pin_b = q.pin_a;

      // Gravity torque offset
      if (q.grav_en) begin
         d.trq = torque_ref_i + TRQ_W'(q.grav_off);
      end else begin
         d.trq = torque_ref_i;
      end

      // Backlash
      bl_abs = (q.bl_amt < 0) ? -q.bl_amt : q.bl_amt;
      bl_allowed = q.pin_b[2] && (bl_abs <= $signed(q.bl_limit));
      ref_step = pos_ref_i - q.prev_ref;
      dir_match = step_matches(ref_step, q.bl_dir);
      d.prev_ref = pos_ref_i;
      d.bl_pulses = to_pulses(q.bl_amt, q.gear_num, q.gear_den);
      if (!q.pin_b[1] || q.pin_b[0] || !bl_allowed) begin
         d.bl_applied = 1'b0;
      end else if (ref_step != 0) begin
         d.bl_applied = dir_match;
      end
      if (q.bl_applied) begin
         d.motor_ref = pos_ref_i + q.bl_pulses;
         d.host_fb = feedback_pos_i - q.bl_pulses;
      end else begin
         d.motor_ref = pos_ref_i;
         d.host_fb = feedback_pos_i;
      end

      // Speed feedback lag filter
      // One step per time unit, gain one over the time constant
      filt_err = ($signed({speed_fb_i, FILT_W'(0)}) - q.filt_acc)
         / $signed({{(SPD_W + FILT_W - 16){1'b0}}, tc_div});
      if (q.filt_tc == 16'h0) begin
         d.filt_acc = {speed_fb_i, FILT_W'(0)};
         d.tick_cnt = 16'h0;
      end else begin
         d.tick_cnt = q.tick_cnt + 16'h1;
         if (q.tick_cnt == 16'(sct_pkg::FILT_UNIT_CYC - 1)) begin
            d.tick_cnt = 16'h0;
            d.filt_acc = q.filt_acc + filt_err;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.cur_mode <= sct_pkg::CUR_MODE_DEF[1:0];
         q.cfg_pend <= sct_pkg::CUR_MODE_DEF << sct_pkg::CUR_MODE_LSB;
         q.cur_gain <= sct_pkg::CUR_GAIN_DEF;
         q.gear_num <= sct_pkg::GEAR_DEF;
         q.gear_den <= sct_pkg::GEAR_DEF;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rdata_o = q.rdata;
   assign motor_pos_ref_o = q.motor_ref;
   assign host_feedback_pos_o = q.host_fb;
   assign torque_cmd_o = q.trq;
   assign speed_fb_filt_o = q.filt_acc[SPD_W+FILT_W-1:FILT_W];
   assign current_mode_o = q.cur_mode;
   assign speed_detect_method_o = q.spd_det;
   assign current_gain_level_o = q.cur_gain;
   assign bl_active_o = q.bl_applied;

endmodule

// >>> sct_pkg.sv
package sct_pkg;
   // Register byte addresses (address is index times four)
   localparam logic [7:0] ADDR_RESTART_CFG = 8'h00;
   localparam logic [7:0] ADDR_GRAV_OFFSET = 8'h04;
   localparam logic [7:0] ADDR_CUR_GAIN = 8'h08;
   localparam logic [7:0] ADDR_SPD_FILT = 8'h0C;
   localparam logic [7:0] ADDR_BL_AMOUNT = 8'h10;
   localparam logic [7:0] ADDR_GEAR_NUM = 8'h14;
   localparam logic [7:0] ADDR_GEAR_DEN = 8'h18;
   localparam logic [7:0] ADDR_BL_LIMIT = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_RESTART = 8'h24;
   // Field positions in the restart configuration word
   localparam int GRAV_EN_BIT = 0;
   localparam int CUR_MODE_LSB = 4;
   localparam int SPD_DET_LSB = 8;
   localparam int BL_DIR_BIT = 12;
   // Reset values and setting limits
   localparam logic [15:0] CUR_GAIN_DEF = 16'h07D0;
   localparam logic [15:0] CUR_GAIN_MIN = 16'h0064;
   localparam logic [15:0] CUR_MODE_DEF = 16'h0001;
   localparam logic [10:0] GRAV_MAX = 11'h3E8;
   localparam logic [19:0] BL_MAX = 20'h7A120;
   localparam logic [31:0] GEAR_DEF = 32'h0000_0001;
   // Filter: time constant unit 0.01 ms at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int FILT_UNIT_NS = 10000;
   localparam int FILT_UNIT_CYC = FILT_UNIT_NS * CLK_MHZ / 1000;
   localparam int FILT_SHIFT = 12;
endpackage

// >>> sct_checker.sv
`timescale 1ns/1ps
module sct_checker (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rotary_motor_i,
   input wire logic servo_on_i,
   input wire logic overtravel_i,
   input wire logic signed [31:0] pos_ref_i,
   input wire logic signed [31:0] feedback_pos_i,
   input wire logic signed [31:0] motor_pos_ref_o,
   input wire logic signed [31:0] host_feedback_pos_o,
   input wire logic [1:0] current_mode_o,
   input wire logic speed_detect_method_o,
   input wire logic [15:0] current_gain_level_o,
   input wire logic bl_active_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   wire logic rs_w = wr_i && addr_i == sct_pkg::ADDR_RESTART;
   // Pin level held through the synchroniser
   sequence servo_low;
      !servo_on_i [*5];
   endsequence
   sequence no_bl;
      $past(rst_b_i) && !bl_active_o && !$past(bl_active_o);
   endsequence
   a_gain_range: assert property (current_gain_level_o >= sct_pkg::CUR_GAIN_MIN &&
      current_gain_level_o <= sct_pkg::CUR_GAIN_DEF) else $error("gain out of range");
   a_servo_off: assert property (servo_low |-> !bl_active_o)
      else $error("backlash with servo off");
   a_travel_off: assert property (overtravel_i [*5] |-> !bl_active_o)
      else $error("backlash in overtravel");
   a_linear_off: assert property (!rotary_motor_i [*5] |-> !bl_active_o)
      else $error("backlash without rotary motor");
   a_ref_plain: assert property (no_bl |-> motor_pos_ref_o == $past(pos_ref_i))
      else $error("motor reference not plain");
   a_fb_plain: assert property (no_bl |-> host_feedback_pos_o == $past(feedback_pos_i))
      else $error("host feedback not plain");
   a_mode_hold: assert property ($changed(current_mode_o) |-> $past(rs_w) || $past(rs_w, 2))
      else $error("mode changed without restart");
   a_det_hold: assert property ($changed(speed_detect_method_o) |-> $past(rs_w) || $past(rs_w, 2))
      else $error("detect method changed without restart");
endmodule

// >>> sct_host.sv
`timescale 1ns/1ps
module sct_host (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic go_i,
   input wire logic signed [31:0] delta_i,
   output logic signed [31:0] pos_o
);
   // One reference step per request, then hold
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_o <= 32'sh0;
      end else if (go_i) begin
         pos_o <= pos_o + delta_i;
      end
   end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [2:0] pin = 3'h3;
   wire logic rotary_motor_i = pin[0];
   wire logic servo_on_i = pin[1];
   wire logic overtravel_i = pin[2];
   logic go = 1'b0;
   logic signed [31:0] delta = 32'sh0;
   logic signed [31:0] pos_ref_i;
   logic signed [31:0] feedback_pos_i = 32'sh1000;
   logic signed [15:0] torque_ref_i = 16'sh03E8;
   logic signed [23:0] speed_fb_i = 24'sh0004D2;
   logic [31:0] rdata_o;
   logic signed [31:0] motor_pos_ref_o;
   logic signed [31:0] host_feedback_pos_o;
   logic signed [15:0] torque_cmd_o;
   logic signed [23:0] speed_fb_filt_o;
   logic [1:0] current_mode_o;
   logic speed_detect_method_o;
   logic [15:0] current_gain_level_o;
   logic bl_active_o;
   int error_cnt = 0;
   int num_checks = 0;
   always #2 clock_i = ~clock_i;
   sct_core sct_core_i (.*);
   sct_host sct_host_i (.clock_i, .rst_b_i, .go_i(go), .delta_i(delta), .pos_o(pos_ref_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic c(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic s;
      repeat (6) @(posedge clock_i);
      #1;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      c(rdata_o, e);
   endtask
   task automatic g(input logic [31:0] v, input logic [31:0] e);
      w(sct_pkg::ADDR_CUR_GAIN, v);
      s();
      c(32'(current_gain_level_o), e);
   endtask
   task automatic mv(input logic signed [31:0] d);
      @(posedge clock_i);
      go <= 1'b1;
      delta <= d;
      @(posedge clock_i);
      go <= 1'b0;
      s();
   endtask
   task automatic bl(input logic e, input logic [31:0] off);
      c(32'(bl_active_o), 32'(e));
      c(motor_pos_ref_o, pos_ref_i + off);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      s();
      c(32'(current_mode_o), 32'h1);
      c(32'(speed_fb_filt_o), 32'h4D2);
      r(sct_pkg::ADDR_STATUS, 32'h2);
      r(8'hFC, 32'h0);
      g(32'h1F4, 32'h1F4);
      g(32'h32, 32'h64);
      g(32'hBB8, 32'h7D0);
      w(sct_pkg::ADDR_GRAV_OFFSET, 32'h64);
      w(sct_pkg::ADDR_RESTART_CFG, 32'h121);
      s();
      c(32'(torque_cmd_o), 32'h3E8);
      c(32'(current_mode_o), 32'h1);
      w(sct_pkg::ADDR_RESTART, 32'h0);
      s();
      c(32'(torque_cmd_o), 32'h44C);
      r(sct_pkg::ADDR_STATUS, 32'hD);
      w(sct_pkg::ADDR_GRAV_OFFSET, 32'hFFFFFC18);
      s();
      c(32'(torque_cmd_o), 32'h0);
      w(sct_pkg::ADDR_GEAR_NUM, 32'h4);
      w(sct_pkg::ADDR_BL_LIMIT, 32'h100000);
      w(sct_pkg::ADDR_BL_AMOUNT, 32'h10000);
      mv(32'sh64);
      bl(1'b1, 32'h6666);
      c(host_feedback_pos_o, 32'hFFFFA99A);
      w(sct_pkg::ADDR_BL_AMOUNT, 32'h10003);
      s();
      bl(1'b1, 32'h6668);
      mv(-32'sh32);
      bl(1'b0, 32'h0);
      mv(32'sh32);
      w(sct_pkg::ADDR_BL_LIMIT, 32'h10002);
      s();
      bl(1'b0, 32'h0);
      w(sct_pkg::ADDR_BL_LIMIT, 32'h10003);
      mv(32'sh32);
      bl(1'b1, 32'h6668);
      for (int k = 0; k < 3; k++) begin
         @(posedge clock_i);
         pin <= 3'h3 ^ (3'h1 << k);
         s();
         bl(1'b0, 32'h0);
         @(posedge clock_i);
         pin <= 3'h3;
      end
      w(sct_pkg::ADDR_RESTART_CFG, 32'h1121);
      mv(32'shA);
      bl(1'b1, 32'h6668);
      w(sct_pkg::ADDR_RESTART, 32'h0);
      mv(32'shA);
      c(32'(bl_active_o), 32'h0);
      mv(-32'shA);
      c(32'(bl_active_o), 32'h1);
      w(sct_pkg::ADDR_SPD_FILT, 32'h1);
      speed_fb_i <= 24'sh000100;
      s();
      c(32'(speed_fb_filt_o), 32'h4D2);
      repeat (2600) @(posedge clock_i);
      #1;
      c(32'(speed_fb_filt_o), 32'h100);
      close_out();
   end
endmodule
bind sct_core sct_checker sct_checker_i (.*);
